// file: hdl/dio_channels.sv
// Eight-channel digital I/O logic: outputs, watchdog, filters, latches, counters, frequency meters.
`timescale 1ns/10ps
`default_nettype none
module dio_channels #(
   parameter int US_PER_MS = 1000                       // Microseconds per millisecond tick.
) (
   input  wire logic                     mclk_i,        // 25 MHz system clock.
   input  wire logic                     rst_n_i,       // Synchronous reset, active low.
   input  wire dio_pkg::bus_req_t        bus_i,         // Register request.
   output logic                   [31:0] rdata_o,       // Read data, cycle after the read strobe.
   input  wire logic              [7:0]  din_i,         // Channel pins, asynchronous.
   input  wire logic              [7:0]  power_on_i,    // Power-up output levels.
   output logic                   [7:0]  dout_o,        // Channel output levels.
   output logic                   [7:0]  dout_oe_o,     // High where a channel drives its pin.
   output logic                          wdog_alarm_o,  // Host watchdog alarm.
   output logic                          irq_o          // Level interrupt.
);
   localparam int NCH    = dio_pkg::NCH;
   localparam int NINT_W = dio_pkg::NINT;

   // Configuration registers.
   logic        latch_en;
   logic        dyn_mode;
   logic [12:0] filter_ms;
   logic [15:0] wdog_s;
   logic [7:0]  out_val;
   logic [7:0]  safe_val;
   logic [7:0]  safe_en;
   logic [7:0]  cnt_en;
   logic [7:0]  freq_en;
   logic [1:0]  scan_mode;
   logic [3:0]  avg_n;
   logic [7:0]  force_dir;
   logic [7:0]  dyn_out;
   logic [NINT_W-1:0] int_stat;
   logic [NINT_W-1:0] int_mask;
   logic [31:0] preset [NCH];

   // Channel state.
   logic [7:0]  din_s1;
   logic [7:0]  din_s2;
   logic [7:0]  filt;
   logic [7:0]  filt_d;
   logic [7:0]  rise;
   logic [7:0]  lat_hi;
   logic [7:0]  lat_lo;
   logic [31:0] count [NCH];
   logic [31:0] freq [NCH];
   logic [7:0]  freq_upd;
   logic [12:0] flt_cnt [NCH];

   // Timing and watchdog.
   logic [4:0]  us_div;
   logic [9:0]  ms_div;
   logic [9:0]  s_div;
   logic        us_tick;
   logic        ms_tick;
   logic        s_tick;
   logic [15:0] wdog_cnt;
   logic        alarm;
   logic        booted;
   logic        activity;
   logic        wr_clr_hi;
   logic        wr_clr_lo;
   logic [7:0]  next_dir;
   logic [7:0]  next_dout;

   // True when an address falls in an eight-word per-channel bank.
   function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
      in_bank = (a & dio_pkg::A_BANK_MSK) == base;
   endfunction

   assign activity  = bus_i.wr | bus_i.rd;
   assign wr_clr_hi = bus_i.wr && bus_i.addr == dio_pkg::A_CMD && bus_i.wdata[dio_pkg::CMD_CLR_HI];
   assign wr_clr_lo = bus_i.wr && bus_i.addr == dio_pkg::A_CMD && bus_i.wdata[dio_pkg::CMD_CLR_LO];

   // Timebase: microsecond, millisecond and second enables from one clock.
   always_ff @(posedge mclk_i) begin
      us_tick <= 1'b0;
      ms_tick <= 1'b0;
      s_tick  <= 1'b0;
      if (!rst_n_i) begin
         us_div <= '0;
         ms_div <= '0;
         s_div  <= '0;
      end else begin
         us_div <= us_div + 5'h01;
         if (us_div == 5'(dio_pkg::CYC_PER_US - 1)) begin
            us_div  <= '0;
            us_tick <= 1'b1;
            ms_div  <= ms_div + 10'h001;
            if (ms_div == 10'(US_PER_MS - 1)) begin
               ms_div  <= '0;
               ms_tick <= 1'b1;
               s_div   <= s_div + 10'h001;
               if (s_div == 10'(dio_pkg::MS_PER_S - 1)) begin
                  s_div  <= '0;
                  s_tick <= 1'b1;
               end
            end
         end
      end
   end

   // Host watchdog; any register access counts as host activity and clears the alarm.
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i || wdog_s == '0) begin
         wdog_cnt <= '0;
         alarm    <= 1'b0;
      end else if (activity) begin
         wdog_cnt <= '0;
         alarm    <= 1'b0;
      end else if (s_tick) begin
         if (wdog_cnt != 16'hFFFF) begin
            wdog_cnt <= wdog_cnt + 16'h0001;
         end
         if (wdog_cnt + 16'h0001 >= wdog_s) begin
            alarm <= 1'b1;
         end
      end
   end

   // Configuration writes.
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         latch_en  <= 1'b0;
         dyn_mode  <= 1'b0;
         filter_ms <= '0;
         wdog_s    <= '0;
         safe_val  <= '0;
         safe_en   <= '0;
         cnt_en    <= '0;
         freq_en   <= '0;
         scan_mode <= dio_pkg::SCAN_RESET;
         avg_n     <= dio_pkg::AVG_RESET;
         force_dir <= '0;
         int_mask  <= '0;
         for (int i = 0; i < NCH; i++) begin
            preset[i] <= '0;
         end
      end else if (bus_i.wr) begin
         unique case (bus_i.addr)
            dio_pkg::A_CTRL: begin
               latch_en <= bus_i.wdata[dio_pkg::CTRL_LATCH];
               dyn_mode <= bus_i.wdata[dio_pkg::CTRL_DYN];
            end
            dio_pkg::A_FILTER: begin
               // Settings above the top of the range are held at the top.
               filter_ms <= (bus_i.wdata[15:0] > 16'(dio_pkg::FILTER_MAX_MS)) ? dio_pkg::FILTER_MAX_MS
                                                                            : bus_i.wdata[12:0];
            end
            dio_pkg::A_WDOG:     wdog_s    <= bus_i.wdata[15:0];
            dio_pkg::A_SAFE_VAL: safe_val  <= bus_i.wdata[7:0];
            dio_pkg::A_SAFE_EN:  safe_en   <= bus_i.wdata[7:0];
            dio_pkg::A_CNT_EN:   cnt_en    <= bus_i.wdata[7:0];
            dio_pkg::A_FREQ_EN:  freq_en   <= bus_i.wdata[7:0];
            dio_pkg::A_SCAN:     scan_mode <= bus_i.wdata[1:0];
            dio_pkg::A_AVG:      avg_n     <= bus_i.wdata[3:0];
            dio_pkg::A_FORCE:    force_dir <= bus_i.wdata[7:0];
            dio_pkg::A_INT_MASK: int_mask  <= bus_i.wdata[NINT_W-1:0];
            default: begin
               if (in_bank(bus_i.addr, dio_pkg::A_PRESET)) begin
                  preset[bus_i.addr[4:2]] <= bus_i.wdata;
               end
            end
         endcase
      end
   end

   // Output requests; the first cycle after reset loads the power-up levels instead.
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         booted  <= 1'b0;
         out_val <= '0;
         dyn_out <= '0;
      end else if (!booted) begin
         booted  <= 1'b1;
         out_val <= power_on_i;
      end else if (bus_i.wr && bus_i.addr == dio_pkg::A_OUT) begin
         for (int i = 0; i < NCH; i++) begin
            if (bus_i.wdata[dio_pkg::OUT_MASK_LSB + i]) begin
               out_val[i] <= bus_i.wdata[i];
               dyn_out[i] <= 1'b1;
            end
         end
      end
   end

   // Direction and level for each pin; the alarm overrides enabled channels.
   always_comb begin
      next_dir  = dyn_mode ? dyn_out : force_dir;
      next_dout = '0;
      for (int i = 0; i < NCH; i++) begin
         if (alarm && safe_en[i]) begin
            next_dout[i] = safe_val[i];
         end else begin
            next_dout[i] = out_val[i];
         end
      end
   end

   // Pin outputs are registered.
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         dout_o       <= '0;
         dout_oe_o    <= '0;
         wdog_alarm_o <= 1'b0;
      end else begin
         dout_o       <= next_dout & next_dir;
         dout_oe_o    <= next_dir;
         wdog_alarm_o <= alarm;
      end
   end

   // Two-stage synchroniser for the pins.
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         din_s1 <= '0;
         din_s2 <= '0;
      end else begin
         din_s1 <= din_i;
         din_s2 <= din_s1;
      end
   end

   // Per-channel filter, counter and frequency meter.
   generate
      for (genvar c = 0; c < NCH; c++) begin : g_ch
         // A change is accepted only after it has held for the full filter time.
         always_ff @(posedge mclk_i) begin
            if (!rst_n_i) begin
               filt[c]    <= 1'b0;
               flt_cnt[c] <= '0;
            end else if (filter_ms == '0 || din_s2[c] == filt[c]) begin
               filt[c]    <= din_s2[c];
               flt_cnt[c] <= '0;
            end else if (ms_tick) begin
               flt_cnt[c] <= flt_cnt[c] + 13'h0001;
               // The first tick only opens the count, so a change is taken late, never early.
               if (flt_cnt[c] >= filter_ms) begin
                  filt[c] <= din_s2[c];
               end
            end
         end

         // Clear loads the preset; an edge in the same cycle is still counted.
         always_ff @(posedge mclk_i) begin
            if (!rst_n_i) begin
               count[c] <= '0;
            end else if (bus_i.wr && bus_i.addr == dio_pkg::A_CNT_CLR && bus_i.wdata[c]) begin
               count[c] <= preset[c] + 32'(rise[c] & cnt_en[c]);
            end else if (rise[c] && cnt_en[c]) begin
               count[c] <= count[c] + 32'h00000001;
            end
         end

         freq_meter u_freq (
            .mclk_i    (mclk_i),
            .rst_n_i   (rst_n_i),
            .en_i      (freq_en[c]),
            .edge_i    (rise[c]),
            .us_tick_i (us_tick),
            .ms_tick_i (ms_tick),
            .mode_i    (scan_mode),
            .avg_i     (avg_n),
            .freq_o    (freq[c]),
            .upd_o     (freq_upd[c])
         );
      end
   endgenerate

   assign rise = filt & ~filt_d;

   // Latches follow the filtered level; a set in the clear cycle wins.
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         filt_d <= '0;
         lat_hi <= '0;
         lat_lo <= '0;
      end else begin
         filt_d <= filt;
         lat_hi <= (wr_clr_hi ? 8'h00 : lat_hi) | (latch_en ? filt : 8'h00);
         lat_lo <= (wr_clr_lo ? 8'h00 : lat_lo) | (latch_en ? ~filt : 8'h00);
      end
   end

   // Sticky interrupt status, write one to clear, new events win over the clear.
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         int_stat <= '0;
         irq_o    <= 1'b0;
      end else begin
         int_stat <= (int_stat & ~((bus_i.wr && bus_i.addr == dio_pkg::A_INT_STAT) ?
                                   bus_i.wdata[NINT_W-1:0] : '0))
                   | {|freq_upd,
                      latch_en & |(~filt & ~lat_lo),
                      latch_en & |(filt & ~lat_hi),
                      s_tick & ~alarm & (wdog_s != '0) & (wdog_cnt + 16'h0001 >= wdog_s) & ~activity};
         irq_o    <= |(int_stat & int_mask);
      end
   end

   // Read data one cycle after the strobe; unmapped addresses read zero.
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         rdata_o <= '0;
      end else if (bus_i.rd) begin
         unique case (bus_i.addr)
            dio_pkg::A_CTRL:     rdata_o <= 32'({dyn_mode, latch_en});
            dio_pkg::A_FILTER:   rdata_o <= 32'(filter_ms);
            dio_pkg::A_WDOG:     rdata_o <= 32'(wdog_s);
            dio_pkg::A_OUT:      rdata_o <= 32'({dyn_out, out_val});
            dio_pkg::A_SAFE_VAL: rdata_o <= 32'(safe_val);
            dio_pkg::A_SAFE_EN:  rdata_o <= 32'(safe_en);
            dio_pkg::A_CNT_EN:   rdata_o <= 32'(cnt_en);
            dio_pkg::A_FREQ_EN:  rdata_o <= 32'(freq_en);
            dio_pkg::A_SCAN:     rdata_o <= 32'(scan_mode);
            dio_pkg::A_AVG:      rdata_o <= 32'(avg_n);
            dio_pkg::A_FORCE:    rdata_o <= 32'(force_dir);
            dio_pkg::A_STATUS:   rdata_o <= {next_dir, lat_lo, lat_hi, filt};
            dio_pkg::A_INT_STAT: rdata_o <= 32'(int_stat);
            dio_pkg::A_INT_MASK: rdata_o <= 32'(int_mask);
            default: begin
               if (in_bank(bus_i.addr, dio_pkg::A_PRESET)) begin
                  rdata_o <= preset[bus_i.addr[4:2]];
               end else if (in_bank(bus_i.addr, dio_pkg::A_COUNT)) begin
                  rdata_o <= count[bus_i.addr[4:2]];
               end else if (in_bank(bus_i.addr, dio_pkg::A_FREQ)) begin
                  rdata_o <= freq[bus_i.addr[4:2]];
               end else begin
                  rdata_o <= '0;
               end
            end
         endcase
      end else begin
         rdata_o <= '0;
      end
   end
endmodule
`default_nettype wire

// file: hdl/dio_pkg.sv
// Package of constants, register offsets and carrier types for the digital I/O channel logic.
package dio_pkg;
   localparam int NCH = 8;

   // Register bus request carried as one struct.
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } bus_req_t;

   // Register byte offsets.
   localparam logic [7:0] A_CTRL     = 8'h00;
   localparam logic [7:0] A_CMD      = 8'h04;
   localparam logic [7:0] A_FILTER   = 8'h08;
   localparam logic [7:0] A_WDOG     = 8'h0C;
   localparam logic [7:0] A_OUT      = 8'h14;
   localparam logic [7:0] A_SAFE_VAL = 8'h18;
   localparam logic [7:0] A_SAFE_EN  = 8'h1C;
   localparam logic [7:0] A_CNT_EN   = 8'h24;
   localparam logic [7:0] A_CNT_CLR  = 8'h28;
   localparam logic [7:0] A_FREQ_EN  = 8'h2C;
   localparam logic [7:0] A_SCAN     = 8'h30;
   localparam logic [7:0] A_AVG      = 8'h34;
   localparam logic [7:0] A_FORCE    = 8'h38;
   localparam logic [7:0] A_STATUS   = 8'h3C;
   localparam logic [7:0] A_INT_STAT = 8'h40;
   localparam logic [7:0] A_INT_MASK = 8'h44;
   localparam logic [7:0] A_PRESET   = 8'h60;
   localparam logic [7:0] A_COUNT    = 8'h80;
   localparam logic [7:0] A_FREQ     = 8'hA0;
   localparam logic [7:0] A_BANK_MSK = 8'hE0;

   // Field positions.
   localparam int CTRL_LATCH = 0;
   localparam int CTRL_DYN   = 1;
   localparam int CMD_CLR_HI = 0;
   localparam int CMD_CLR_LO = 1;
   localparam int OUT_MASK_LSB = 8;
   localparam int INT_WDOG = 0;
   localparam int INT_HI   = 1;
   localparam int INT_LO   = 2;
   localparam int INT_FREQ = 3;
   localparam int NINT     = 4;

   // Reset values.
   localparam logic [3:0] AVG_RESET  = 4'h1;
   localparam logic [1:0] SCAN_RESET = 2'h0;

   // Scan mode codes.
   localparam logic [1:0] SCAN_SLOW   = 2'h0;
   localparam logic [1:0] SCAN_FAST   = 2'h1;
   localparam logic [1:0] SCAN_SINGLE = 2'h2;

   // Timing.
   localparam int CLK_NS     = 40;
   localparam int US_NS      = 1000;
   localparam int CYC_PER_US = (US_NS + CLK_NS - 1) / CLK_NS;
   localparam int MS_PER_S   = 1000;
   localparam logic [12:0] FILTER_MAX_MS = 13'h1964;
   localparam logic [9:0]  GATE_SLOW_MS  = 10'h3E8;
   localparam logic [9:0]  GATE_FAST_MS  = 10'h064;

   // Result scaling, frequency reported in units of 0.01 Hz.
   localparam logic [31:0] SCALE_SLOW  = 32'h00000064;
   localparam logic [31:0] SCALE_FAST  = 32'h000003E8;
   localparam logic [31:0] CENTI_NUM   = 32'h05F5E100;
   localparam logic [27:0] PERIOD_MAX  = 28'h5F5E100;
endpackage

// file: hdl/freq_meter.sv
// Per-channel frequency meter with gate and single-period modes and moving average.
`timescale 1ns/10ps
`default_nettype none
module freq_meter (
   input  wire logic        mclk_i,     // System clock.
   input  wire logic        rst_n_i,    // Synchronous reset, active low.
   input  wire logic        en_i,       // Measurement enable.
   input  wire logic        edge_i,     // Filtered rising edge pulse.
   input  wire logic        us_tick_i,  // One microsecond enable.
   input  wire logic        ms_tick_i,  // One millisecond enable.
   input  wire logic [1:0]  mode_i,     // Scan mode.
   input  wire logic [3:0]  avg_i,      // Samples averaged: 1, 2, 4 or 8.
   output logic      [31:0] freq_o,     // Averaged result in 0.01 Hz.
   output logic             upd_o       // Pulse when freq_o updates.
);
   typedef enum logic [1:0] {D_IDLE = 2'b01, D_RUN = 2'b10} div_state_t;

   div_state_t  dstate;
   logic [9:0]  gate_ms;
   logic [15:0] gate_cnt;
   logic [27:0] period_us;
   logic        seen_edge;
   logic [31:0] quo;
   logic [28:0] rem;
   logic [27:0] den;
   logic [4:0]  step;
   logic [31:0] sample;
   logic        sample_v;
   logic [31:0] hist [dio_pkg::NCH];
   logic [34:0] sum;
   logic [28:0] trial;

   // Log2 of the averaging depth; unknown codes fall back to no averaging.
   function automatic logic [1:0] avg_shift(input logic [3:0] a);
      unique case (a)
         4'h2:    avg_shift = 2'h1;
         4'h4:    avg_shift = 2'h2;
         4'h8:    avg_shift = 2'h3;
         default: avg_shift = 2'h0;
      endcase
   endfunction

   // Gate window: count edges over a fixed window, scale to 0.01 Hz.
   always_ff @(posedge mclk_i) begin
      sample_v <= 1'b0;
      if (!rst_n_i || !en_i || mode_i == dio_pkg::SCAN_SINGLE) begin
         gate_ms  <= '0;
         gate_cnt <= '0;
      end else begin
         if (ms_tick_i && gate_ms == ((mode_i == dio_pkg::SCAN_FAST) ? dio_pkg::GATE_FAST_MS
                                                                     : dio_pkg::GATE_SLOW_MS) - 10'h001) begin
            gate_ms  <= '0;
            gate_cnt <= '0;
            sample_v <= 1'b1;
            if (mode_i == dio_pkg::SCAN_FAST) begin
               sample <= 32'(gate_cnt + 16'(edge_i)) * dio_pkg::SCALE_FAST;
            end else begin
               sample <= 32'(gate_cnt + 16'(edge_i)) * dio_pkg::SCALE_SLOW;
            end
         end else begin
            if (ms_tick_i) begin
               gate_ms <= gate_ms + 10'h001;
            end
            if (edge_i) begin
               gate_cnt <= gate_cnt + 16'h0001;
            end
         end
      end
      if (dstate == D_RUN && step == 5'h1F) begin
         sample_v <= 1'b1;
         sample   <= {quo[30:0], trial >= {1'b0, den}};
      end
   end

   // Single period: time one input period in microseconds; a long period saturates.
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i || !en_i || mode_i != dio_pkg::SCAN_SINGLE) begin
         period_us <= '0;
         seen_edge <= 1'b0;
      end else if (edge_i) begin
         period_us <= '0;
         seen_edge <= 1'b1;
      end else if (us_tick_i && period_us != dio_pkg::PERIOD_MAX) begin
         period_us <= period_us + 28'h0000001;
      end
   end

   assign trial = {rem[27:0], quo[31]};

   // Serial divider turns the period into a frequency; an edge during a division is skipped.
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         dstate <= D_IDLE;
         step   <= '0;
      end else begin
         unique case (dstate)
            D_IDLE: begin
               if (edge_i && seen_edge && en_i && mode_i == dio_pkg::SCAN_SINGLE && period_us != '0) begin
                  quo    <= dio_pkg::CENTI_NUM;
                  rem    <= '0;
                  den    <= period_us;
                  step   <= '0;
                  dstate <= D_RUN;
               end
            end
            D_RUN: begin
               quo  <= {quo[30:0], trial >= {1'b0, den}};
               rem  <= (trial >= {1'b0, den}) ? trial - {1'b0, den} : trial;
               step <= step + 5'h01;
               if (step == 5'h1F) begin
                  dstate <= D_IDLE;
               end
            end
         endcase
      end
   end

   // Sum the newest samples for the chosen depth.
   always_comb begin
      sum = '0;
      for (int i = 0; i < dio_pkg::NCH; i++) begin
         if (i < (1 << avg_shift(avg_i))) begin
            sum = sum + 35'(hist[i]);
         end
      end
   end

   // Sample history and averaged result.
   always_ff @(posedge mclk_i) begin
      upd_o <= 1'b0;
      if (!rst_n_i) begin
         freq_o <= '0;
         for (int i = 0; i < dio_pkg::NCH; i++) begin
            hist[i] <= '0;
         end
      end else if (sample_v) begin
         hist[0] <= sample;
         for (int i = 1; i < dio_pkg::NCH; i++) begin
            hist[i] <= hist[i - 1];
         end
      end else if (dstate == D_IDLE) begin
         freq_o <= 32'(sum >> avg_shift(avg_i));
         upd_o  <= (32'(sum >> avg_shift(avg_i)) != freq_o);
      end
   end
endmodule
`default_nettype wire

// file: sim/dio_channels_sva.sv
// Checker of the digital I/O block port behaviour.
`timescale 1ns/10ps
`default_nettype none
module dio_chk (
   input wire logic              mclk_i,       // Clock.
   input wire logic              rst_n_i,      // Reset, active low.
   input wire dio_pkg::bus_req_t bus_i,        // Register request.
   input wire logic [31:0]       rdata_o,      // Read data.
   input wire logic [7:0]        dout_o,       // Output levels.
   input wire logic [7:0]        dout_oe_o,    // Output enables.
   input wire logic              wdog_alarm_o  // Watchdog alarm.
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   // A read of the given offset was taken on the previous edge.
   sequence s_rd(a);
      $past(bus_i.rd) && $past(bus_i.addr) == a;
   endsequence
   a_read_idle_zero: assert property (!$past(bus_i.rd) |-> rdata_o == 32'h0)
      else $error("read data not zero when idle");
   a_cmd_reads_zero: assert property (s_rd(dio_pkg::A_CMD) |-> rdata_o == 32'h0)
      else $error("command register read not zero");
   a_activity_clears: assert property ((bus_i.wr || bus_i.rd) |-> ##2 !wdog_alarm_o)
      else $error("alarm stands after host activity");
   a_oe_after_write: assert property (|(dout_oe_o & ~$past(dout_oe_o)) |->
      $past(bus_i.wr, 2) || $past(bus_i.wr, 3)) else $error("direction changed with no write");
   a_dout_after_write: assert property (dout_o != $past(dout_o) |-> $past(bus_i.wr, 2)
      || $past(bus_i.wr, 3) || wdog_alarm_o != $past(wdog_alarm_o, 2)) else $error("output moved alone");
   a_status_dir: assert property (s_rd(dio_pkg::A_STATUS) |-> rdata_o[31:24] == dout_oe_o)
      else $error("status direction differs from enables");
   a_out_readback: assert property ((s_rd(dio_pkg::A_OUT) ##0 !wdog_alarm_o) |-> (rdata_o[7:0] & dout_oe_o) == dout_o)
      else $error("output levels differ from readback");
   a_filter_clamp: assert property (s_rd(dio_pkg::A_FILTER) |-> rdata_o <= 32'h00001964)
      else $error("filter setting above limit");
endmodule
bind dio_channels dio_chk i_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
   .dout_o(dout_o), .dout_oe_o(dout_oe_o), .wdog_alarm_o(wdog_alarm_o));
`default_nettype wire

// file: sim/dio_channels_tb_top.sv
// Testbench of the digital I/O block through its register port and pins.
`timescale 1ns/10ps
`default_nettype none
module dio_channels_tb_top;
   logic              mclk_i = 1'b0;
   logic              rst_n_i = 1'b0;
   logic              go = 1'b0;
   logic [7:0]        din;
   dio_pkg::bus_req_t bus = '0;
   logic [31:0]       rdata_o;
   logic [7:0]        dout_o;
   logic [7:0]        dout_oe_o;
   logic              irq_o;
   logic              wdog_alarm_o;
   int                failures = 0;
   int                num_checks = 0;
   // A short millisecond keeps the gate windows within a brief run.
   always #20 mclk_i = ~mclk_i;
   pulse_src i_src (.mclk_i(mclk_i), .go_i(go), .mask_i(8'h0C), .din_o(din));
   dio_channels #(.US_PER_MS(2)) i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_i(bus), .rdata_o(rdata_o),
      .din_i(din), .power_on_i(8'hA5), .dout_o(dout_o), .dout_oe_o(dout_oe_o), .wdog_alarm_o(wdog_alarm_o),
      .irq_o(irq_o));
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge mclk_i);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge mclk_i);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge mclk_i);
      bus.rd <= 1'b0;
      @(negedge mclk_i);
      chk($sformatf("reg %h", a), rdata_o, e);
   endtask
   // Each run of n toggles gives n/2 rising edges and ends low.
   task automatic pulse(input int n);
      @(posedge mclk_i);
      go <= 1'b1;
      cyc(n);
      go <= 1'b0;
      cyc(12);
   endtask
   task automatic test_done();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Main sequence: direction, latches, interrupt, counters, filter, frequency.
   initial begin
      cyc(8);
      rst_n_i <= 1'b1;
      cyc(2);
      wr(dio_pkg::A_FORCE, 32'hF0);
      cyc(3);
      chk("dout", 32'(dout_o), 32'hA0);
      chk("oe", 32'(dout_oe_o), 32'hF0);
      wr(dio_pkg::A_CTRL, 32'h2);
      rd(dio_pkg::A_STATUS, 32'h0);
      wr(dio_pkg::A_OUT, 32'h0301);
      cyc(3);
      chk("oe", 32'(dout_oe_o), 32'h03);
      wr(dio_pkg::A_CTRL, 32'h1);
      wr(dio_pkg::A_OUT, 32'h0F0F);
      wr(dio_pkg::A_INT_MASK, 32'h2);
      rd(dio_pkg::A_OUT, 32'h0FAF);
      chk("oe", 32'(dout_oe_o), 32'hF0);
      pulse(4);
      rd(dio_pkg::A_STATUS, 32'hF0FF0C00);
      chk("irq", 32'(irq_o), 32'h1);
      wr(dio_pkg::A_INT_MASK, 32'h0);
      cyc(3);
      chk("irq", 32'(irq_o), 32'h0);
      wr(dio_pkg::A_INT_STAT, 32'h2);
      wr(dio_pkg::A_INT_MASK, 32'h2);
      cyc(3);
      chk("irq", 32'(irq_o), 32'h0);
      wr(dio_pkg::A_CMD, 32'h0);
      rd(dio_pkg::A_STATUS, 32'hF0FF0C00);
      wr(dio_pkg::A_CMD, 32'h1);
      rd(dio_pkg::A_STATUS, 32'hF0FF0000);
      wr(dio_pkg::A_CTRL, 32'h0);
      wr(dio_pkg::A_CMD, 32'h2);
      pulse(4);
      rd(dio_pkg::A_STATUS, 32'hF0000000);
      wr(dio_pkg::A_PRESET + 8'h08, 32'h64);
      wr(dio_pkg::A_CNT_EN, 32'h4);
      wr(dio_pkg::A_CNT_CLR, 32'h4);
      rd(dio_pkg::A_COUNT + 8'h08, 32'h64);
      pulse(6);
      rd(dio_pkg::A_COUNT + 8'h08, 32'h67);
      rd(dio_pkg::A_COUNT + 8'h0C, 32'h0);
      wr(dio_pkg::A_FILTER, 32'hFFFF);
      rd(dio_pkg::A_FILTER, 32'h1964);
      wr(dio_pkg::A_FILTER, 32'h1);
      pulse(6);
      rd(dio_pkg::A_COUNT + 8'h08, 32'h67);
      wr(dio_pkg::A_FILTER, 32'h0);
      rd(dio_pkg::A_FREQ + 8'h08, 32'h0);
      wr(dio_pkg::A_SCAN, 32'(dio_pkg::SCAN_FAST));
      wr(dio_pkg::A_FREQ_EN, 32'h4);
      @(posedge mclk_i);
      go <= 1'b1;
      cyc(11000);
      rd(dio_pkg::A_FREQ + 8'h08, 32'd2500 * dio_pkg::SCALE_FAST);
      // Three full windows later the four newest samples in the history are all whole-window samples.
      wr(dio_pkg::A_AVG, 32'h4);
      cyc(15000);
      rd(dio_pkg::A_FREQ + 8'h08, 32'h000009C4 * dio_pkg::SCALE_FAST);
      // Watchdog: stay off the bus until the next second tick raises the alarm.
      wr(dio_pkg::A_SAFE_VAL, 32'h50);
      wr(dio_pkg::A_SAFE_EN, 32'h30);
      wr(dio_pkg::A_WDOG, 32'h1);
      for (int i = 0; i < 30000 && !wdog_alarm_o; i++) cyc(1);
      chk("alarm", 32'(wdog_alarm_o), 32'h1);
      chk("dout", 32'(dout_o), 32'h90);
      rd(dio_pkg::A_INT_STAT, 32'hD);
      cyc(3);
      chk("alarm", 32'(wdog_alarm_o), 32'h0);
      chk("dout", 32'(dout_o), 32'hA0);
      test_done();
   end
endmodule
`default_nettype wire

// file: sim/pulse_src.sv
// Field-side source that drives pulse trains onto the channel pins.
`timescale 1ns/10ps
`default_nettype none
module pulse_src (
   input  wire logic       mclk_i,  // Clock.
   input  wire logic       go_i,    // Toggle while high.
   input  wire logic [7:0] mask_i,  // Channels that pulse.
   output var  logic [7:0] din_o    // Pin levels.
);
   // Masked pins toggle each cycle while running and all pins sit low otherwise, as a pulled-down line does.
   initial din_o = 8'h00;
   always @(posedge mclk_i) din_o <= go_i ? (din_o ^ mask_i) : 8'h00;
endmodule
`default_nettype wire
